// ### src/bls_supervisor.v
/*
 Digital control of a buck and two linear regulators: clock select,
 soft start, overcurrent and overvoltage protection, power good,
 supervisor reset and an APB register slave.
 Assumes pclk at 50 MHz; pins are asynchronous and synchronised here.
*/
// Behaviour
// - Without sync clock, switch at internal 750kHz rate.
// - Sync clock 500kHz to 1000kHz; lock on its first rising edge.
// - No sync edge for two 1.3us periods: back to internal clock.
// - Buck enable rise starts 5.5ms soft start, then closes loop.
// - Sync input ignored while soft start runs.
// - Buck enable low shuts buck switches and reference; oscillator stops only while supply ok is low.
// - Buck power good high only when enabled and within 8%.
// - Second buck power good output is always the inverse.
// - Each switching cycle end, overcurrent adds two to 4 bit counter.
// - No overcurrent: counter minus one, saturating at 0000.
// - Counter at 1111 shuts buck and resets soft start.
// - After overcurrent shutdown wait 16 clocks, then restart soft start.
// - Overvoltage for 32 consecutive clocks shuts buck, resets soft start.
// - After overvoltage, restart only when enable or supply toggles.
// - Linear enable high turns both linear regulators on, low off.
// - Linear power good low if either out 15%, or disabled.
// - Reset held while supply low and 25ms after it recovers.
// - Active-low reset low, active-high reset high while held.
// - Reset asserts before undervoltage lockout turns outputs off.
// - Both enables low puts whole device into full shutdown.
// - Reset hold time is a parameter, 2.5ms per nF.
`timescale 1ns/1ps
`default_nettype none
`include "bls_regs.vh"
module bls_supervisor #(
   parameter SS_CYC = `BLS_SS_SW_CYC,
   parameter RST_HOLD_CYC = `BLS_RST_HOLD_SW_CYC,
   parameter INT_DIV = `BLS_INT_DIV
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire buck_enable_in,
   input wire linear_enable_in,
   input wire sync_in,
   input wire supply_ok_in,
   input wire supply_above_reset_in,
   input wire buck_in_window_in,
   input wire buck_overcurrent_in,
   input wire buck_overvoltage_in,
   input wire linear_reg_a_ok_in,
   input wire linear_reg_b_ok_in,
   output reg buck_switch_en,
   output reg buck_softstart,
   output reg buck_loop_closed,
   output reg buck_on_sync,
   output reg switch_cycle_start,
   output reg linear_reg_a_en,
   output reg linear_reg_b_en,
   output reg buck_power_good,
   output reg buck_power_good_n,
   output reg linear_power_good,
   output reg host_reset,
   output reg host_reset_n,
   output reg full_shutdown
);
   localparam ST_OFF = 3'h0;
   localparam ST_SS = 3'h1;
   localparam ST_RUN = 3'h2;
   localparam ST_OC_WAIT = 3'h3;
   localparam ST_OV_LATCH = 3'h4;

   wire [9:0] pin_s;
   reg [31:0] ctrl_q;
   reg sync_d1_q;
   reg [7:0] div_q;
   reg [7:0] loss_q;
   reg [7:0] sync_per_q;
   reg on_sync_q;
   reg [2:0] st_q;
   reg [23:0] ss_q;
   reg [3:0] fcnt_q;
   reg [4:0] wait_q;
   reg [5:0] ov_q;
   reg oc_smp_q;
   reg ov_smp_q;
   reg en_prev_q;
   reg sup_prev_q;
   reg [23:0] hold_q;
   reg [3:0] fcnt_d;
   wire access;
   wire use_sync;
   wire buck_en;
   wire lin_en;
   wire sync_rise;
   wire int_tick;
   wire cyc_end;
   wire en_rise;
   wire sup_rise;

   bls_sync_2ff #(
      .W(10)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({sync_in, buck_enable_in, linear_enable_in, supply_ok_in,
          supply_above_reset_in, buck_in_window_in, buck_overcurrent_in,
          buck_overvoltage_in, linear_reg_a_ok_in, linear_reg_b_ok_in}),
      .q(pin_s)
   );

   // Pin and software enables are combined by AND; software resets to on
   assign buck_en = pin_s[8] & ctrl_q[`BLS_CTRL_BUCK_EN] & pin_s[6];
   assign lin_en = pin_s[7] & ctrl_q[`BLS_CTRL_LIN_EN] & pin_s[6];
   assign sync_rise = pin_s[9] & ~sync_d1_q;
   assign int_tick = (div_q == INT_DIV - 1);
   // Soft start always runs on the oscillator, even if a lock is still held
   assign use_sync = on_sync_q && st_q != ST_SS;
   // A sync edge ends the cycle when locked, otherwise the oscillator does
   assign cyc_end = use_sync ? sync_rise : int_tick;
   assign access = psel && !penable;
   assign en_rise = pin_s[8] & ~en_prev_q;
   assign sup_rise = pin_s[6] & ~sup_prev_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_d1_q <= 1'b0;
         div_q <= 8'h00;
         loss_q <= 8'h00;
         on_sync_q <= 1'b0;
         sync_per_q <= 8'h00;
         en_prev_q <= 1'b0;
         // Idle level of supply good is high; pin_s starts low, so sup_rise pulses once after reset if supply ok is high
         sup_prev_q <= 1'b1;
      end else begin
         sync_d1_q <= pin_s[9];
         en_prev_q <= pin_s[8];
         sup_prev_q <= pin_s[6];
         // Oscillator stops only while supply ok is low; buck shutdown alone keeps it running for reset timing
         if (int_tick || (!buck_en && !pin_s[6]))
            div_q <= 8'h00;
         else
            div_q <= div_q + 8'h01;
         if (sync_rise)
            loss_q <= 8'h00;
         else if (loss_q != 8'hFF)
            loss_q <= loss_q + 8'h01;
         if (sync_rise)
            sync_per_q <= 8'h00;
         else if (sync_per_q != 8'hFF)
            sync_per_q <= sync_per_q + 8'h01;
         // Edge lock ignored during soft start; loss timeout falls back cleanly
         if (st_q == ST_SS || !buck_en)
            on_sync_q <= 1'b0;
         else if (sync_rise)
            on_sync_q <= 1'b1;
         else if (loss_q >= `BLS_SYNC_LOSS_CYC)
            on_sync_q <= 1'b0;
      end
   end

   // Overcurrent counter next value
   always @* begin
      fcnt_d = fcnt_q;
      if (oc_smp_q) begin
         if (fcnt_q > `BLS_OC_FULL - `BLS_OC_STEP_UP)
            fcnt_d = `BLS_OC_FULL;
         else
            fcnt_d = fcnt_q + `BLS_OC_STEP_UP;
      end else if (fcnt_q != 4'h0) begin
         fcnt_d = fcnt_q - 4'h1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_OFF;
         ss_q <= 24'h000000;
         fcnt_q <= 4'h0;
         wait_q <= 5'h00;
         ov_q <= 6'h00;
         oc_smp_q <= 1'b0;
         ov_smp_q <= 1'b0;
      end else begin
         if (cyc_end) begin
            oc_smp_q <= pin_s[3];
            ov_smp_q <= pin_s[2];
         end
         if (ov_smp_q && (st_q == ST_SS || st_q == ST_RUN)) begin
            if (ov_q != `BLS_OV_PERSIST)
               ov_q <= ov_q + 6'h01;
         end else begin
            ov_q <= 6'h00;
         end
         case (st_q)
            ST_OFF: begin
               ss_q <= 24'h000000;
               fcnt_q <= 4'h0;
               if (buck_en)
                  st_q <= ST_SS;
            end
            ST_SS, ST_RUN: begin
               if (!buck_en) begin
                  st_q <= ST_OFF;
               end else if (ov_q == `BLS_OV_PERSIST) begin
                  st_q <= ST_OV_LATCH;
                  ss_q <= 24'h000000;
               end else if (fcnt_q == `BLS_OC_FULL) begin
                  st_q <= ST_OC_WAIT;
                  ss_q <= 24'h000000;
                  wait_q <= 5'h00;
               end else begin
                  if (cyc_end)
                     fcnt_q <= fcnt_d;
                  if (st_q == ST_SS && int_tick) begin
                     if (ss_q == SS_CYC - 1)
                        st_q <= ST_RUN;
                     else
                        ss_q <= ss_q + 24'h000001;
                  end
               end
            end
            ST_OC_WAIT: begin
               fcnt_q <= 4'h0;
               if (!buck_en)
                  st_q <= ST_OFF;
               else if (wait_q == `BLS_OC_WAIT - 1)
                  st_q <= ST_SS;
               else
                  wait_q <= wait_q + 5'h01;
            end
            ST_OV_LATCH: begin
               // Only a fresh enable edge or supply return clears the latch
               if (en_rise || sup_rise)
                  st_q <= ST_OFF;
            end
            default: st_q <= ST_OFF;
         endcase
      end
   end

   // Supervisor hold counter on oscillator ticks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 24'h000000;
         host_reset <= 1'b1;
         host_reset_n <= 1'b0;
      end else begin
         if (!pin_s[5])
            hold_q <= 24'h000000;
         else if (int_tick && hold_q != RST_HOLD_CYC)
            hold_q <= hold_q + 24'h000001;
         // Reset threshold sits above lockout, so reset leads the shutdown
         host_reset <= !pin_s[5] || hold_q != RST_HOLD_CYC;
         host_reset_n <= pin_s[5] && hold_q == RST_HOLD_CYC;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buck_switch_en <= 1'b0;
         buck_softstart <= 1'b0;
         buck_loop_closed <= 1'b0;
         buck_on_sync <= 1'b0;
         switch_cycle_start <= 1'b0;
         linear_reg_a_en <= 1'b0;
         linear_reg_b_en <= 1'b0;
         buck_power_good <= 1'b0;
         buck_power_good_n <= 1'b1;
         linear_power_good <= 1'b0;
         full_shutdown <= 1'b1;
      end else begin
         buck_switch_en <= buck_en && (st_q == ST_SS || st_q == ST_RUN);
         buck_softstart <= buck_en && st_q == ST_SS;
         buck_loop_closed <= buck_en && st_q == ST_RUN;
         buck_on_sync <= use_sync;
         switch_cycle_start <= buck_en && cyc_end;
         linear_reg_a_en <= lin_en;
         linear_reg_b_en <= lin_en;
         buck_power_good <= buck_en && st_q == ST_RUN && pin_s[4];
         buck_power_good_n <= !(buck_en && st_q == ST_RUN && pin_s[4]);
         linear_power_good <= lin_en && pin_s[1] && pin_s[0];
         full_shutdown <= !pin_s[8] && !pin_s[7];
      end
   end

   // APB slave, zero wait states; read data prepared in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `BLS_CTRL_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         // Write lands only at the edge that completes the access phase
         if (psel && penable && pready && pwrite && paddr == `BLS_ADDR_CTRL)
            ctrl_q <= {30'h00000000, pwdata[1:0]};
         pslverr <= 1'b0;
         if (access) begin
            prdata <= 32'h00000000;
            case (paddr)
               `BLS_ADDR_CTRL: begin
                  if (!pwrite)
                     prdata <= ctrl_q;
               end
               `BLS_ADDR_STAT: begin
                  if (!pwrite)
                     prdata <= {20'h00000, fcnt_q, 1'b0, st_q, on_sync_q,
                                host_reset, buck_power_good, linear_power_good};
                  else
                     pslverr <= 1'b1;
               end
               `BLS_ADDR_FCNT: begin
                  if (!pwrite)
                     prdata <= {2'h0, ov_q, hold_q};
                  else
                     pslverr <= 1'b1;
               end
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule // bls_supervisor
`default_nettype wire

// ### inc/bls_regs.vh
/*
 Timing constants, register offsets and field positions of the
 buck and linear supervisor logic. Assumes a 50 MHz pclk.
*/
`ifndef BLS_REGS_VH
`define BLS_REGS_VH
`define BLS_CLK_HZ 50000000
`define BLS_INT_SW_HZ 750000
`define BLS_INT_DIV ((`BLS_CLK_HZ + `BLS_INT_SW_HZ / 2) / `BLS_INT_SW_HZ)
`define BLS_INT_PERIOD_NS 1300
`define BLS_SYNC_LOSS_CYC ((2 * `BLS_INT_PERIOD_NS) / 20)
`define BLS_SS_US 5500
`define BLS_SS_SW_CYC ((`BLS_SS_US * 750) / 1000)
`define BLS_RST_HOLD_US 25000
`define BLS_RST_HOLD_SW_CYC ((`BLS_RST_HOLD_US * 750 + 999) / 1000)
`define BLS_OC_STEP_UP 4'h2
`define BLS_OC_FULL 4'hF
`define BLS_OC_WAIT 16
`define BLS_OV_PERSIST 32
`define BLS_ADDR_CTRL 12'h000
`define BLS_ADDR_STAT 12'h004
`define BLS_ADDR_FCNT 12'h008
`define BLS_CTRL_BUCK_EN 0
`define BLS_CTRL_LIN_EN 1
`define BLS_CTRL_RESET 32'h00000003
`endif

// ### src/bls_sync_2ff.v
/*
 Two-flop level synchroniser, parameterised width.
 Assumes inputs asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bls_sync_2ff #(
   parameter W = 1
) (
   input wire clk,
   input wire rst_n,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // bls_sync_2ff
`default_nettype wire

// ### bench/bls_assertions.sv
/* Port checker for bls_supervisor.
 Assumes one pclk domain and presetn async active low. */
`timescale 1ns/1ps
`default_nettype none
module bls_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic buck_enable_in,
   input wire logic linear_enable_in,
   input wire logic supply_above_reset_in,
   input wire logic buck_power_good,
   input wire logic buck_power_good_n,
   input wire logic buck_switch_en,
   input wire logic buck_softstart,
   input wire logic buck_on_sync,
   input wire logic switch_cycle_start,
   input wire logic linear_reg_a_en,
   input wire logic linear_reg_b_en,
   input wire logic linear_power_good,
   input wire logic host_reset,
   input wire logic host_reset_n,
   input wire logic full_shutdown
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Six cycles cover the pin synchroniser and output register
   sequence s_buck_off; !buck_enable_in [*6]; endsequence
   sequence s_both_off; (!buck_enable_in && !linear_enable_in) [*6]; endsequence
   sequence s_sup_low; !supply_above_reset_in [*6]; endsequence
   property p_pg_inv; buck_power_good_n == !buck_power_good; endproperty
   a_pg_inv: assert property (p_pg_inv)
      else $error("buck good pair split");
   property p_pg_en; buck_power_good |-> buck_switch_en; endproperty
   a_pg_en: assert property (p_pg_en)
      else $error("buck good while off");
   property p_lin_pg; linear_power_good |-> linear_reg_a_en && linear_reg_b_en; endproperty
   a_lin_pg: assert property (p_lin_pg)
      else $error("linear good while off");
   property p_lin_pair; linear_reg_a_en == linear_reg_b_en; endproperty
   a_lin_pair: assert property (p_lin_pair)
      else $error("linear enables differ");
   property p_ss_sync; buck_softstart |-> !buck_on_sync; endproperty
   a_ss_sync: assert property (p_ss_sync)
      else $error("sync used in soft start");
   property p_buck_off; s_buck_off |-> !buck_switch_en && !buck_power_good; endproperty
   a_buck_off: assert property (p_buck_off)
      else $error("buck on with pin low");
   property p_shut; s_both_off |-> full_shutdown; endproperty
   a_shut: assert property (p_shut)
      else $error("no full shutdown");
   property p_rst_comp; host_reset_n == !host_reset; endproperty
   a_rst_comp: assert property (p_rst_comp)
      else $error("reset pair split");
   property p_rst_low; s_sup_low |-> host_reset; endproperty
   a_rst_low: assert property (p_rst_low)
      else $error("reset free on low supply");
   property p_cyc; switch_cycle_start |=> !switch_cycle_start [*8]; endproperty
   a_cyc: assert property (p_cyc)
      else $error("switch cycle too short");
endmodule // bls_assertions
bind bls_supervisor bls_assertions bls_assertions_inst (.*);
`default_nettype wire

// ### bench/bls_host_model.sv
/* Host processor model: drives both enable pins.
 Assumes want_* commands from the bench, reset from the device. */
`timescale 1ns/1ps
`default_nettype none
module bls_host_model (
   input wire logic pclk,
   input wire logic host_reset,
   input wire logic want_buck,
   input wire logic want_lin,
   output var logic buck_enable_in,
   output var logic linear_enable_in
);
   // A held processor cannot keep its enable lines up
   always @(posedge pclk) begin
      buck_enable_in <= want_buck & ~host_reset;
      linear_enable_in <= want_lin & ~host_reset;
   end
endmodule // bls_host_model
`default_nettype wire

// ### bench/tb_top.sv
/* Self-checking bench for bls_supervisor.
 Assumes 50 MHz pclk, short soft start and reset hold. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int DIV = 67;
   localparam int HOLD = 8;
   logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, pready, pslverr;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic er, want_buck = '0, want_lin = '0, sync_in = '0, sync_run = '0;
   logic supply_ok_in = 1'h1, supply_above_reset_in = 1'h1, buck_in_window_in = '0;
   logic buck_overcurrent_in = '0, buck_overvoltage_in = '0;
   logic linear_reg_a_ok_in = 1'h1, linear_reg_b_ok_in = 1'h1, buck_enable_in, linear_enable_in;
   logic buck_switch_en, buck_softstart, buck_loop_closed, buck_on_sync, switch_cycle_start;
   logic linear_reg_a_en, linear_reg_b_en, buck_power_good, buck_power_good_n;
   logic linear_power_good, host_reset, host_reset_n, full_shutdown;
   int n_fail = 0, cmp_count = 0, wcnt, sdiv = 0;
   wire [4:0] mon = {host_reset, buck_softstart, buck_loop_closed, buck_on_sync, buck_switch_en};
   bls_supervisor #(.SS_CYC(4), .RST_HOLD_CYC(HOLD), .INT_DIV(DIV)) bls_supervisor_inst (.*);
   bls_host_model bls_host_model_inst (.*);
   initial begin
      forever #10 pclk = ~pclk;
   end
   // Sync clock of 60 pclk; stands low once stopped
   always @(posedge pclk) begin
      sdiv <= (sdiv == 29) ? 0 : sdiv + 1;
      if (sdiv == 29) sync_in <= sync_run & ~sync_in;
   end
   task automatic complete_run();
      $display("Compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t ns got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int b, input logic v, input int lim);
      wcnt = 0;
      while (mon[b] !== v) begin
         @(posedge pclk);
         wcnt++;
         if (wcnt > lim) begin
            n_fail++;
            $display("[FAIL] %0t ns wait ran out", $time);
            complete_run();
         end
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      wcnt = 0;
      do begin
         @(posedge pclk);
         wcnt++;
      end while (pready !== 1'h1 && wcnt < 20);
      rd = prdata;
      er = pslverr;
      psel <= '0;
      penable <= '0;
      if (wcnt >= 20) begin
         chk(pready, 1);
         complete_run();
      end
      @(posedge pclk);
   endtask
   task automatic t_boot();
      chk({host_reset, host_reset_n}, 2'h2);
      wt(4, 0, 2000);
      chk(wcnt >= HOLD * DIV - DIV, 1);
      apb(1'h0, 12'h000, '0);
      chk(rd, 32'h3);
      apb(1'h1, 12'h004, 32'hFF);
      chk(er, 1);
      apb(1'h0, 12'h0FC, '0);
      chk(er, 1);
      $display("boot done");
   endtask
   task automatic t_soft();
      sync_run <= 1'h1;
      buck_in_window_in <= 1'h1;
      want_lin <= 1'h1;
      want_buck <= 1'h1;
      wt(3, 1, 100);
      wt(2, 1, 2000);
      chk(wcnt >= 3 * DIV, 1);
      wt(1, 1, 300);
      repeat (10) @(posedge pclk);
      chk({buck_power_good, buck_power_good_n, linear_power_good}, 3'h5);
      buck_in_window_in <= '0;
      repeat (10) @(posedge pclk);
      chk({buck_power_good, buck_power_good_n}, 2'h1);
      buck_in_window_in <= 1'h1;
      sync_run <= '0;
      wt(1, 0, 400);
      chk({wcnt >= 60, buck_switch_en}, 2'h3);
      $display("soft start and sync done");
   endtask
   task automatic t_faults();
      buck_overcurrent_in <= 1'h1;
      wt(0, 0, 2000);
      chk(wcnt >= 6 * DIV, 1);
      buck_overcurrent_in <= '0;
      wt(3, 1, 100);
      chk(wcnt >= 16 && wcnt <= 24, 1);
      wt(2, 1, 2000);
      repeat (20 * DIV) @(posedge pclk);
      apb(1'h0, 12'h004, '0);
      chk(rd[11:8], 4'h0);
      buck_overvoltage_in <= 1'h1;
      wt(0, 0, 300);
      chk(wcnt >= 32, 1);
      buck_overvoltage_in <= '0;
      repeat (400) @(posedge pclk);
      chk({buck_softstart, buck_switch_en}, 2'h0);
      want_buck <= '0;
      repeat (10) @(posedge pclk);
      want_buck <= 1'h1;
      wt(3, 1, 100);
      $display("faults done");
   endtask
   task automatic t_lin();
      want_lin <= '0;
      repeat (10) @(posedge pclk);
      chk({linear_reg_a_en, linear_reg_b_en, linear_power_good}, 3'h0);
      want_lin <= 1'h1;
      linear_reg_b_ok_in <= '0;
      repeat (10) @(posedge pclk);
      chk({linear_reg_a_en, linear_reg_b_en, linear_power_good}, 3'h6);
      linear_reg_b_ok_in <= 1'h1;
      want_lin <= '0;
      want_buck <= '0;
      repeat (10) @(posedge pclk);
      chk(full_shutdown, 1);
      want_lin <= 1'h1;
      repeat (10) @(posedge pclk);
      chk(full_shutdown, 0);
      $display("linear done");
   endtask
   task automatic t_supply();
      supply_above_reset_in <= '0;
      repeat (20) @(posedge pclk);
      chk({host_reset, host_reset_n}, 2'h2);
      supply_above_reset_in <= 1'h1;
      repeat (300) @(posedge pclk);
      supply_above_reset_in <= '0;
      repeat (10) @(posedge pclk);
      supply_above_reset_in <= 1'h1;
      wt(4, 0, 2000);
      chk(wcnt >= HOLD * DIV - DIV, 1);
      $display("supply done");
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_boot();
      t_soft();
      t_faults();
      t_lin();
      t_supply();
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
